/* hw/acc_exec_pkg.sv */
/*
 Constants for the accumulator instruction executor: AHB register map,
 instruction encodings, flag positions, reset values and cycle counts.
 Assumes a 14-bit instruction word and an 8-bit data path.
*/
package acc_exec_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_INSTR   = 8'h00;  // Write: instruction to run
   localparam logic [7:0] OFS_ACC     = 8'h04;  // Accumulator
   localparam logic [7:0] OFS_STATUS  = 8'h08;  // Flags and busy
   localparam logic [7:0] OFS_PRESC   = 8'h0C;  // Prescaler configuration
   localparam logic [7:0] OFS_IRQCTL  = 8'h10;  // Interrupt control
   localparam logic [7:0] OFS_PC      = 8'h14;  // Program counter
   localparam logic [7:0] OFS_PUSH    = 8'h18;  // Write: push onto stack
   localparam logic [7:0] OFS_DEPTH   = 8'h1C;  // Stack depth
   localparam logic [7:0] OFS_FILE    = 8'h80;  // 0x80..0xFF file window

   // Instruction encodings
   localparam logic [13:0] ENC_COPY_MASK = 14'h3F80;
   localparam logic [13:0] ENC_COPY      = 14'h0080;
   localparam logic [13:0] ENC_PRESC     = 14'h0062;
   localparam logic [13:0] ENC_RETIRQ    = 14'h0009;
   localparam logic [13:0] ENC_OP_MASK   = 14'h3F00;
   localparam logic [13:0] ENC_SUB       = 14'h0200;
   localparam logic [13:0] ENC_SWAP      = 14'h0E00;

   // Field positions
   localparam int DEST_BIT  = 7;
   localparam int FADDR_MSB = 6;
   localparam int FLAG_C    = 0;
   localparam int FLAG_HB   = 1;
   localparam int FLAG_Z    = 2;
   localparam int BUSY_BIT  = 3;
   localparam int IRQ_ON_BIT = 7;

   // Reset values
   localparam logic [7:0]  PRESC_RST = 8'hFF;
   localparam logic [7:0]  IRQ_RST   = 8'h00;
   localparam logic [12:0] PC_RST    = 13'h0000;

   // Cycle counts
   localparam int CYC_RETIRQ = 2;
endpackage : acc_exec_pkg

/* hw/return_stack.sv */
/*
 Hardware return stack of program-counter values with push and pop.
 Assumes push and pop never arrive in the same cycle.
*/
`timescale 1ns/100ps
module return_stack #(
   parameter int DEPTH = 8,
   parameter int AW    = 13
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic          push,
   input  wire logic [AW-1:0] push_val,
   input  wire logic          pop,
   output logic      [AW-1:0] stack_head,
   output logic      [3:0]    depth
);
   logic [AW-1:0] mem_q [DEPTH];
   logic [2:0]    ptr_q, ptr_d;
   logic [3:0]    cnt_q, cnt_d;

   // Circular pointer, wraps on overflow
   always_comb begin
      ptr_d = ptr_q;
      cnt_d = cnt_q;
      if (push) begin
         ptr_d = ptr_q + 3'h1;
         if (cnt_q != 4'(DEPTH)) cnt_d = cnt_q + 4'h1;
      end else if (pop) begin
         ptr_d = ptr_q - 3'h1;
         if (cnt_q != 4'h0) cnt_d = cnt_q - 4'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ptr_q <= 3'h0;
         cnt_q <= 4'h0;
      end else begin
         ptr_q <= ptr_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage without reset
   always_ff @(posedge ref_clk) begin
      if (push) mem_q[ptr_q] <= push_val;
   end

   assign stack_head = mem_q[ptr_q - 3'h1];
   assign depth      = cnt_q;
endmodule : return_stack

/* hw/acc_instr_exec.sv */
/*
 Executes copy, prescaler load, return from interrupt, subtract and nibble
 exchange instructions written over an AHB-Lite slave port.
 Assumes one AHB-Lite master doing single word transfers on ref_clk.
*/
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
module acc_instr_exec #(
   parameter int FILE_WORDS  = 128,
   parameter int STACK_DEPTH = 8
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             master_irq_on
);
   typedef enum logic [1:0] {EX_IDLE, EX_POP, EX_LOAD} ex_state_t;

   // Result of one subtraction with its flags
   function automatic logic [10:0] sub_flags(input logic [7:0] f, input logic [7:0] w);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, f} - {1'b0, w};
      low  = {1'b0, f[3:0]} - {1'b0, w[3:0]};
      sub_flags = {~low[4], (full[7:0] == 8'h00), ~full[8], full[7:0]};
   endfunction : sub_flags

   logic [7:0]  file_q [FILE_WORDS];
   logic [7:0]  acc_q, acc_d;
   logic [7:0]  presc_q, presc_d;
   logic [7:0]  irqctl_q, irqctl_d;
   logic [12:0] pc_q, pc_d;
   logic        c_q, c_d, hb_q, hb_d, z_q, z_d;
   ex_state_t   st_q, st_d;
   logic        wr_q, wr_d, ph_q, ph_d;
   logic [7:0]  ad_q, ad_d;
   logic [31:0] rd_q, rd_d;
   logic        fw_en;
   logic [6:0]  fw_addr;
   logic [7:0]  fw_data;
   logic        pop, push;
   logic [12:0] head;
   logic [3:0]  depth;
   logic [13:0] ins;
   logic [7:0]  fval;
   logic [10:0] sres;
   logic [7:0]  swp;
   logic        bus_wr, take;

   assign take   = hsel && hready && htrans[1];
   assign bus_wr = ph_q && wr_q;
   assign ins    = hwdata[13:0];
   assign fval   = file_q[ins[acc_exec_pkg::FADDR_MSB:0]];
   assign sres   = sub_flags(fval, acc_q);
   assign swp    = {fval[3:0], fval[7:4]};

   return_stack #(.DEPTH(STACK_DEPTH), .AW(13)) u_stack (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .push      (push),
      .push_val  (hwdata[12:0]),
      .pop       (pop),
      .stack_head(head),
      .depth     (depth)
   );

   // Bus phase tracking and instruction execution
   always_comb begin
      st_d = st_q; acc_d = acc_q; presc_d = presc_q; irqctl_d = irqctl_q;
      pc_d = pc_q; c_d = c_q; hb_d = hb_q; z_d = z_q;
      wr_d = wr_q; ad_d = ad_q; ph_d = ph_q; rd_d = rd_q;
      fw_en = 1'b0; fw_addr = ins[6:0]; fw_data = acc_q;
      pop = 1'b0; push = 1'b0;
      if (hready || st_q == EX_IDLE) begin
         ph_d = take;
         if (take) begin
            wr_d = hwrite;
            ad_d = haddr[7:0];
         end
      end
      // Return sequence: idle first cycle, pop and load pc second
      unique case (st_q)
         EX_POP: st_d = EX_LOAD;
         EX_LOAD: begin
            pc_d = head;
            pop  = 1'b1;
            irqctl_d[acc_exec_pkg::IRQ_ON_BIT] = 1'b1;
            st_d = EX_IDLE;
         end
         EX_IDLE: begin
            if (bus_wr && ad_q == acc_exec_pkg::OFS_INSTR) begin
               pc_d = pc_q + 13'h1;
               if ((ins & acc_exec_pkg::ENC_COPY_MASK) == acc_exec_pkg::ENC_COPY) begin
                  fw_en = 1'b1;
               end else if (ins == acc_exec_pkg::ENC_PRESC) begin
                  presc_d = acc_q;
               end else if (ins == acc_exec_pkg::ENC_RETIRQ) begin
                  st_d = EX_POP;
               end else if ((ins & acc_exec_pkg::ENC_OP_MASK) == acc_exec_pkg::ENC_SUB) begin
                  if (ins[acc_exec_pkg::DEST_BIT]) begin
                     fw_en = 1'b1; fw_data = sres[7:0];
                  end else acc_d = sres[7:0];
                  c_d  = sres[8];
                  z_d  = sres[9];
                  hb_d = sres[10];
               end else if ((ins & acc_exec_pkg::ENC_OP_MASK) == acc_exec_pkg::ENC_SWAP) begin
                  if (ins[acc_exec_pkg::DEST_BIT]) begin
                     fw_en = 1'b1; fw_data = swp;
                  end else acc_d = swp;
               end
            end else if (bus_wr) begin
               unique case (ad_q)
                  acc_exec_pkg::OFS_ACC:    acc_d = hwdata[7:0];
                  acc_exec_pkg::OFS_PRESC:  presc_d = hwdata[7:0];
                  acc_exec_pkg::OFS_IRQCTL: irqctl_d = hwdata[7:0];
                  acc_exec_pkg::OFS_PC:     pc_d = hwdata[12:0];
                  acc_exec_pkg::OFS_PUSH:   push = 1'b1;
                  acc_exec_pkg::OFS_STATUS: begin
                     c_d = hwdata[0]; hb_d = hwdata[1]; z_d = hwdata[2];
                  end
                  default: if (ad_q[7]) begin
                     fw_en = 1'b1; fw_addr = ad_q[6:0] >> 0; fw_data = hwdata[7:0];
                  end
               endcase
            end
         end
      endcase
      // Read data captured at address phase
      if (take && !hwrite) begin
         unique case (haddr[7:0])
            acc_exec_pkg::OFS_ACC:    rd_d = {24'h0, acc_q};
            acc_exec_pkg::OFS_STATUS: rd_d = {28'h0, st_q != EX_IDLE, z_q, hb_q, c_q};
            acc_exec_pkg::OFS_PRESC:  rd_d = {24'h0, presc_q};
            acc_exec_pkg::OFS_IRQCTL: rd_d = {24'h0, irqctl_q};
            acc_exec_pkg::OFS_PC:     rd_d = {19'h0, pc_q};
            acc_exec_pkg::OFS_DEPTH:  rd_d = {28'h0, depth};
            default: rd_d = haddr[7] ? {24'h0, file_q[haddr[6:0]]} : 32'h0;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st_q <= EX_IDLE; acc_q <= 8'h00;
         presc_q <= acc_exec_pkg::PRESC_RST; irqctl_q <= acc_exec_pkg::IRQ_RST;
         pc_q <= acc_exec_pkg::PC_RST; c_q <= 1'b0; hb_q <= 1'b0; z_q <= 1'b0;
         wr_q <= 1'b0; ad_q <= 8'h00; ph_q <= 1'b0; rd_q <= 32'h0;
         hreadyout <= 1'b1; master_irq_on <= 1'b0;
         hresp <= 1'b0;
      end else begin
         st_q <= st_d; acc_q <= acc_d; presc_q <= presc_d; irqctl_q <= irqctl_d;
         pc_q <= pc_d; c_q <= c_d; hb_q <= hb_d; z_q <= z_d;
         wr_q <= wr_d; ad_q <= ad_d; ph_q <= ph_d; rd_q <= rd_d;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         master_irq_on <= irqctl_d[acc_exec_pkg::IRQ_ON_BIT];
      end
   end

   // File storage
   always_ff @(posedge ref_clk) begin
      if (fw_en) file_q[fw_addr] <= fw_data;
   end

   assign hrdata = rd_q;

   // return sets enable two cycles on
   irq_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == EX_POP |=> ##1 irqctl_q[7]) else $error("irq enable not set");
   pc_pop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == EX_LOAD |=> pc_q == $past(head)) else $error("pc not popped");
   presc_ld_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == EX_IDLE && bus_wr && ad_q == 8'h00 && ins == 14'h0062
      |=> presc_q == $past(acc_q)) else $error("prescaler not loaded");
   sub_carry_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == EX_IDLE && bus_wr && ad_q == 8'h00 && ins[13:8] == 6'h02
      |=> c_q == ($past(fval) >= $past(acc_q))) else $error("carry wrong");
   sub_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == EX_IDLE && bus_wr && ad_q == 8'h00 && ins[13:8] == 6'h02
      |=> z_q == ($past(fval) == $past(acc_q))) else $error("zero wrong");
   sub_dest_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == EX_IDLE && bus_wr && ad_q == 8'h00 && ins[13:7] == 7'h04
      |=> acc_q == $past(fval) - $past(acc_q)) else $error("sub result wrong");
   swap_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == EX_IDLE && bus_wr && ad_q == 8'h00 && ins[13:7] == 7'h1C
      |=> acc_q == {$past(fval[3:0]), $past(fval[7:4])} && $stable(c_q))
      else $error("swap wrong");
   copy_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == EX_IDLE && bus_wr && ad_q == 8'h00 && ins[13:7] == 7'h01
      |=> $stable(c_q) && $stable(z_q) && $stable(hb_q)) else $error("copy hit flags");
   sub_time_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st_q == EX_IDLE && bus_wr && ad_q == 8'h00 && ins[13:8] == 6'h02
      |=> st_q == EX_IDLE) else $error("subtract not single cycle");
endmodule : acc_instr_exec

/* test/tb_accumulator_instr_exec.sv */
/*
 Self-checking bench for the accumulator instruction executor: drives the
 AHB-Lite slave port with single word transfers and checks register results.
 Assumes zero wait states, data in bits 7:0 and file register n at 0x80+n.
*/
`timescale 1ns/100ps
module tb_accumulator_instr_exec;
   logic        ref_clk;
   logic        rst_n;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        master_irq_on;
   logic [31:0] r;
   int          errors;
   int          checks;

   acc_instr_exec uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .master_irq_on(master_irq_on)
   );

   // Clock at 200 MHz
   always #2.5 ref_clk = ~ref_clk;

   function automatic logic [31:0] a(input logic [7:0] o);
      return {24'h00, o};
   endfunction : a

   // Compare one value and count it
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One AHB-Lite single transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] wd,
                      output logic [31:0] rdat);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= ad;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] o, input logic [31:0] d);
      logic [31:0] dummy;
      bus(1'b1, a(o), d, dummy);
   endtask : wr

   task automatic rd(input logic [7:0] o, output logic [31:0] d);
      bus(1'b0, a(o), 32'h0000_0000, d);
   endtask : rd

   task automatic run(input logic [13:0] ins);
      wr(acc_exec_pkg::OFS_INSTR, {18'h00000, ins});
   endtask : run

   // subtract with flags, result routed by destination bit
   task automatic sub_case(input logic [7:0] f, input logic [7:0] w, input logic d);
      logic [7:0] res;
      res = f - w;
      wr(8'h90, {24'h00, f});
      wr(acc_exec_pkg::OFS_ACC, {24'h00, w});
      run(acc_exec_pkg::ENC_SUB | {6'h00, d, 7'h10});
      rd(d ? 8'h90 : acc_exec_pkg::OFS_ACC, r);
      chk("sub_result", r, {24'h00, res});
      rd(d ? acc_exec_pkg::OFS_ACC : 8'h90, r);
      chk("sub_other", r, {24'h00, d ? w : f});
      rd(acc_exec_pkg::OFS_STATUS, r);
      chk("sub_flags", {28'h0, r[3:0]}, {29'h0, res == 8'h00, f[3:0] >= w[3:0], f >= w});
   endtask : sub_case

   task automatic results;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   // Watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge ref_clk);
      errors++;
      results();
   end

   // Main sequence
   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      errors = 0;
      checks = 0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(acc_exec_pkg::OFS_ACC, r);    chk("acc_rst", r, 32'h0000_0000);
      rd(acc_exec_pkg::OFS_PRESC, r);  chk("presc_rst", r, 32'h0000_00FF);
      rd(acc_exec_pkg::OFS_IRQCTL, r); chk("irq_rst", r, 32'h0000_0000);
      rd(acc_exec_pkg::OFS_STATUS, r); chk("status_rst", r, 32'h0000_0000);
      rd(acc_exec_pkg::OFS_DEPTH, r);  chk("depth_rst", r, 32'h0000_0000);
      chk("irq_pin_rst", {31'h0, master_irq_on}, 32'h0000_0000);
      $display("test reset done");
      // borrow, zero and nibble borrow cases
      sub_case(8'h03, 8'h02, 1'b1);
      sub_case(8'h02, 8'h02, 1'b1);
      sub_case(8'h01, 8'h02, 1'b0);
      sub_case(8'h10, 8'h01, 1'b0);
      $display("test subtract done");
      run(acc_exec_pkg::ENC_COPY | 14'h0008);
      rd(8'h88, r);                    chk("copy_file", r, 32'h0000_000F);
      rd(acc_exec_pkg::OFS_STATUS, r); chk("copy_flags", r, 32'h0000_0001);
      run(acc_exec_pkg::ENC_PRESC);
      rd(acc_exec_pkg::OFS_PRESC, r);  chk("presc_load", r, 32'h0000_000F);
      rd(acc_exec_pkg::OFS_STATUS, r); chk("presc_flags", r, 32'h0000_0001);
      $display("test copy and prescaler done");
      wr(8'h8C, 32'h0000_00A5);
      run(acc_exec_pkg::ENC_SWAP | 14'h000C);
      rd(acc_exec_pkg::OFS_ACC, r);    chk("swap_acc", r, 32'h0000_005A);
      rd(8'h8C, r);                    chk("swap_keep", r, 32'h0000_00A5);
      run(acc_exec_pkg::ENC_SWAP | 14'h008C);
      rd(8'h8C, r);                    chk("swap_file", r, 32'h0000_005A);
      rd(acc_exec_pkg::OFS_STATUS, r); chk("swap_flags", r, 32'h0000_0001);
      $display("test exchange done");
      // return pops stack head into pc, enable set
      wr(acc_exec_pkg::OFS_PUSH, 32'h0000_0123);
      rd(acc_exec_pkg::OFS_DEPTH, r);  chk("depth_push", r, 32'h0000_0001);
      run(acc_exec_pkg::ENC_RETIRQ);
      repeat (acc_exec_pkg::CYC_RETIRQ) @(posedge ref_clk);
      rd(acc_exec_pkg::OFS_PC, r);     chk("ret_pc", r, 32'h0000_0123);
      rd(acc_exec_pkg::OFS_DEPTH, r);  chk("ret_depth", r, 32'h0000_0000);
      rd(acc_exec_pkg::OFS_IRQCTL, r); chk("ret_irq_bit", {31'h0, r[7]}, 32'h0000_0001);
      chk("ret_irq_pin", {31'h0, master_irq_on}, 32'h0000_0001);
      rd(8'h40, r);                    chk("unmapped", r, 32'h0000_0000);
      chk("resp_okay", {31'h0, hresp}, 32'h0000_0000);
      $display("test return done");
      results();
   end
endmodule : tb_accumulator_instr_exec
